/* sbc_ctrl.sv */
// Memory command controller: burst stop, byte masking, bank close and auto-close
// Behaviour
// R1: Burst stop is chip select low with CA0..CA3 driven high, high, low, low.
// R2: Burst stop only during a burst, at most half burst length minus one after.
// R3: A stopped burst lasts twice the cycles from access to burst stop.
// R4: Turnaround spacing after a stopped burst uses its effective length.
// R5: Burst stop affects only the latest read or write.
// R6: Device ends the stopped burst after latency plus strobe offset.
// R7: Burst stop only an even number of cycles after the access.
// R8: Only one burst stop per read or write.
// R9: One write byte mask per byte lane, timed like the data.
// R10: Bank close is chip select low with CA0..CA3 high, high, low, high.
// R11: All-bank flag on CA4 closes all; else CA7..CA9 pick one bank.
// R12: No activate until the matching close time has passed.
// R13: Device close times: all-bank longer on eight banks, equal on four.
// R14: Read to close waits half burst length and the row-active minimum.
// R15: Read to close adds the read-to-close time, from effective length.
// R16: Activate a closed bank only after its close time.
// R17: Write to close waits write latency, half burst, one, and recovery.
// R18: Recovery counts from the end of the write burst.
// R19: Device writes the array only after a full four-beat group.
// R20: Auto-close flag on falling CA0 selects automatic bank close.
// R21: Read auto-close starts at the later of two read-derived points.
// R22: Activate after auto-close needs close time and row cycle time.
// R23: Burst lengths 4, 8 and 16; write beats run to the length.
// R24: Write auto-close starts recovery cycles after the burst ends.
// R25: Per-bank open state and timers gate activate, read and write; bank close uses the timers only.
`timescale 1ns/10ps
`default_nettype none
module sbc_ctrl #(
  parameter int NUM_BANKS     = sbc_pkg::NUM_BANKS_DEF,
  parameter int BURST_LENGTH  = sbc_pkg::BURST_LENGTH_DEF,
  parameter int READ_LATENCY  = sbc_pkg::READ_LATENCY_DEF,
  parameter int WRITE_LATENCY = sbc_pkg::WRITE_LATENCY_DEF,
  parameter int DATA_BYTES    = sbc_pkg::DATA_BYTES_DEF
) (
  // Clock and reset
  input  wire logic                                i_clock,
  input  wire logic                                i_nrst,
  // Request port
  input  wire logic                                i_req_valid,
  input  wire sbc_pkg::sbc_req_type                i_req_cmd,
  input  wire logic [2:0]                          i_req_bank,
  input  wire logic                                i_req_auto_close,
  input  wire logic                                i_req_all_banks,
  output logic                                     o_req_done,
  output logic                                     o_req_err,
  // Write data source
  output logic                                     o_wr_pull,
  input  wire logic [8*DATA_BYTES-1:0]             i_wr_data,
  input  wire logic [DATA_BYTES-1:0]               i_wr_mask,
  // Memory pins
  output logic                                     o_mem_clk,
  output logic                                     o_cs_n,
  output logic [sbc_pkg::CA_WIDTH-1:0]             o_ca,
  output logic [8*DATA_BYTES-1:0]                  o_dq,
  output logic                                     o_dq_oe,
  output logic [DATA_BYTES-1:0]                    o_write_byte_mask,
  output logic                                     o_dqs,
  output logic                                     o_dqs_oe
);

  // ****************************************
  // Derived spacings, in memory clock cycles; WR_LEAD and FULL_BEATS count i_clock cycles
  // ****************************************
  localparam int W        = sbc_pkg::CNT_W;
  localparam int CAW      = sbc_pkg::CA_WIDTH;
  localparam int HALF_BL  = BURST_LENGTH / 2;
  localparam int RTP_M    = (sbc_pkg::READ_TO_CLOSE_CYC > 2) ? sbc_pkg::READ_TO_CLOSE_CYC : 2;
  localparam int SKEW     = sbc_pkg::OUTPUT_STROBE_SKEW_CYC;
  localparam logic [W-1:0] RD_CLOSE_W  = W'(HALF_BL + RTP_M - 2);
  localparam logic [W-1:0] WR_CLOSE_W  = W'(WRITE_LATENCY + HALF_BL
                                            + sbc_pkg::WRITE_RECOVERY_CYC + 1);
  localparam logic [W-1:0] RD_STOP_CW  = W'((RTP_M - 2 > 1) ? RTP_M - 2 : 1);
  localparam logic [W-1:0] WR_STOP_CW  = W'(WRITE_LATENCY + sbc_pkg::WRITE_RECOVERY_CYC + 1);
  localparam logic [W-1:0] RD_TO_WR    = W'(READ_LATENCY + SKEW + HALF_BL + 1 - WRITE_LATENCY);
  localparam logic [W-1:0] WR_TO_RD    = W'(WRITE_LATENCY + 1 + HALF_BL
                                            + sbc_pkg::WRITE_TO_READ_CYC);
  localparam logic [W-1:0] RD_STOP_TO_WR = W'(READ_LATENCY + SKEW + 1 - WRITE_LATENCY);
  localparam logic [W-1:0] WR_STOP_TO_RD = W'(WRITE_LATENCY + 1 + sbc_pkg::WRITE_TO_READ_CYC);
  localparam logic [W-1:0] SAME_GAP    = W'(HALF_BL);
  localparam logic [W-1:0] STOP_LAST   = W'(HALF_BL - 1);
  localparam logic [W-1:0] WR_LEAD     = W'(2 * WRITE_LATENCY + 1);
  localparam logic [W-1:0] FULL_BEATS  = W'(BURST_LENGTH);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (NUM_BANKS != 4 && NUM_BANKS != 8) begin : g_bad_banks
    $error("NUM_BANKS must be 4 or 8");
  end
  if (BURST_LENGTH != 4 && BURST_LENGTH != 8 && BURST_LENGTH != 16) begin : g_bad_bl // R23
    $error("BURST_LENGTH must be 4, 8 or 16");
  end
  if (READ_LATENCY < WRITE_LATENCY || WRITE_LATENCY < 1) begin : g_bad_lat
    $error("latencies out of range");
  end
  if (NUM_BANKS == 4 && sbc_pkg::ALL_BANK_CLOSE_CYC != sbc_pkg::SINGLE_CLOSE_CYC)
  begin : g_bad_close // R13
    $error("four-bank parts need equal close times");
  end

  // ****************************************
  // Rising-edge command word
  // ****************************************
  function automatic logic [CAW-1:0] sbc_rise_word(input sbc_pkg::sbc_req_type cmd,
                                                   input logic [2:0] bank,
                                                   input logic all_banks);
    logic [CAW-1:0] w;
    w = '0;
    w[sbc_pkg::BANK_LSB +: 3] = bank;
    unique case (cmd)
      sbc_pkg::REQ_ACTIVATE: w[1:0] = sbc_pkg::CA_ACTIVATE;
      sbc_pkg::REQ_READ:     w[2:0] = sbc_pkg::CA_READ;
      sbc_pkg::REQ_WRITE:    w[2:0] = sbc_pkg::CA_WRITE;
      sbc_pkg::REQ_CLOSE: begin
        w[3:0] = sbc_pkg::CA_BANK_CLOSE; // R10
        w[sbc_pkg::ALL_BANK_BIT] = all_banks; // R11
      end
      default: begin
        w = '0;
        w[3:0] = sbc_pkg::CA_BURST_STOP; // R1
      end
    endcase
    return w;
  endfunction : sbc_rise_word

  // ****************************************
  // Bank trackers
  // ****************************************
  sbc_bank_if #(.NB(NUM_BANKS)) bus ();

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    sbc_bank #(
      .IDX (b)
    ) u_bank (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .bus     (bus.bank)
    );
  end

  // ****************************************
  // State
  // ****************************************
  sbc_pkg::sbc_state_type state;
  logic                   phase;
  logic [CAW-1:0]         fall_word;
  logic [W-1:0]           age;
  logic                   have_acc;
  logic                   stopped;
  logic                   last_wr;
  logic                   last_auto;
  logic [2:0]             last_bank;
  logic [W-1:0]           gap_wait;
  logic [W-1:0]           rd_block;
  logic [W-1:0]           wr_block;
  logic [W-1:0]           wr_delay;
  logic [W-1:0]           beats_sent;
  logic [W-1:0]           beats_lim;
  logic                   wr_run;

  // ****************************************
  // Request decode and legality
  // ****************************************
  // Four-bank parts ignore the top bank bit, so it is sent as zero
  wire [2:0]     bank_idx   = (NUM_BANKS == 4) ? {1'b0, i_req_bank[1:0]} : i_req_bank; // R11
  wire [2:0]     stop_bank  = last_bank;
  wire           tick       = phase;
  wire           is_act     = (i_req_cmd == sbc_pkg::REQ_ACTIVATE);
  wire           is_rd      = (i_req_cmd == sbc_pkg::REQ_READ);
  wire           is_wr      = (i_req_cmd == sbc_pkg::REQ_WRITE);
  wire           is_close   = (i_req_cmd == sbc_pkg::REQ_CLOSE);
  wire           is_stop    = (i_req_cmd == sbc_pkg::REQ_STOP);
  wire           ok_act     = bus.may_act[bank_idx]; // R12 R16 R22
  wire           ok_access  = bus.may_acc[bank_idx] && (gap_wait <= W'(1));
  wire           ok_rd      = ok_access && (rd_block <= W'(1)); // R4
  wire           ok_wr      = ok_access && (wr_block <= W'(1)); // R4
  wire           ok_close   = i_req_all_banks ? (&bus.may_close)
                                              : bus.may_close[bank_idx]; // R14 R17 R18
  wire           ok_stop    = have_acc && !stopped && !last_auto // R5 R8
                              && !age[0] && (age <= STOP_LAST); // R2 R7
  wire           legal      = (is_act && ok_act) || (is_rd && ok_rd) || (is_wr && ok_wr)
                              || (is_close && ok_close) || (is_stop && ok_stop);
  wire           take       = tick && i_req_valid;
  wire           accept     = take && legal;
  wire           do_access  = accept && (is_rd || is_wr);
  wire           do_stop    = accept && is_stop;
  wire [W-1:0]   eff_beats  = W'({age, 1'b0}); // R3
  wire [CAW-1:0] next_rise  = sbc_rise_word(i_req_cmd, bank_idx, i_req_all_banks);
  wire [CAW-1:0] next_fall  = {{(CAW-1){1'b0}}, (is_rd || is_wr) && i_req_auto_close}; // R20
  wire [NUM_BANKS-1:0] req_onehot  = NUM_BANKS'(1) << bank_idx;
  wire [NUM_BANKS-1:0] stop_onehot = NUM_BANKS'(1) << stop_bank;

  // ****************************************
  // Strobes to the bank trackers
  // ****************************************
  assign bus.tick           = tick;
  assign bus.act            = (accept && is_act) ? req_onehot : '0;
  assign bus.close          = (accept && is_close)
                              ? (i_req_all_banks ? '1 : req_onehot) : '0; // R11
  assign bus.acc            = do_access ? req_onehot : (do_stop ? stop_onehot : '0); // R5
  assign bus.acc_auto       = do_access && i_req_auto_close; // R20
  assign bus.acc_close_wait = do_stop ? (last_wr ? WR_STOP_CW : RD_STOP_CW) // R15
                                      : (is_wr ? WR_CLOSE_W : RD_CLOSE_W); // R14 R17
  assign bus.auto_wait      = is_wr ? WR_CLOSE_W : RD_CLOSE_W; // R21 R24
  assign bus.close_time     = i_req_all_banks ? W'(sbc_pkg::ALL_BANK_CLOSE_CYC)
                                              : W'(sbc_pkg::SINGLE_CLOSE_CYC); // R12

  // ****************************************
  // Command sequencer and memory clock
  // ****************************************
  // Clock is divided by two so each half of the command word gets half a period of setup
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state      <= sbc_pkg::ST_IDLE;
      phase      <= 1'b0;
      o_mem_clk  <= 1'b0;
      o_cs_n     <= 1'b1;
      o_ca       <= '0;
      fall_word  <= '0;
      o_req_done <= 1'b0;
      o_req_err  <= 1'b0;
    end else begin
      phase      <= ~phase;
      o_mem_clk  <= ~phase;
      o_req_done <= accept;
      o_req_err  <= take && !legal;
      unique case (state)
        sbc_pkg::ST_RISE: begin
          o_ca  <= fall_word;
          state <= sbc_pkg::ST_FALL;
        end
        default: begin
          if (accept) begin
            o_cs_n    <= 1'b0;
            o_ca      <= next_rise;
            fall_word <= next_fall;
            state     <= sbc_pkg::ST_RISE;
          end else if (tick) begin
            o_cs_n <= 1'b1;
            o_ca   <= '0;
            state  <= sbc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Burst tracking and turnaround
  // ****************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      age       <= '0;
      have_acc  <= 1'b0;
      stopped   <= 1'b0;
      last_wr   <= 1'b0;
      last_auto <= 1'b0;
      last_bank <= '0;
      gap_wait  <= '0;
      rd_block  <= '0;
      wr_block  <= '0;
    end else if (tick) begin
      if (age != '1) age <= age + 1'b1;
      if (gap_wait != '0) gap_wait <= gap_wait - 1'b1;
      if (rd_block != '0) rd_block <= rd_block - 1'b1;
      if (wr_block != '0) wr_block <= wr_block - 1'b1;
      if (do_access) begin
        age       <= W'(1);
        have_acc  <= 1'b1;
        stopped   <= 1'b0; // R8
        last_wr   <= is_wr;
        last_auto <= i_req_auto_close;
        last_bank <= bank_idx;
        gap_wait  <= SAME_GAP;
        rd_block  <= is_wr ? WR_TO_RD : SAME_GAP;
        wr_block  <= is_wr ? SAME_GAP : RD_TO_WR;
      end else if (do_stop) begin
        stopped  <= 1'b1; // R8
        gap_wait <= '0;
        rd_block <= last_wr ? WR_STOP_TO_RD : '0; // R4
        wr_block <= last_wr ? '0 : RD_STOP_TO_WR; // R4
      end
    end
  end

  // ****************************************
  // Write data beats
  // ****************************************
  wire last_beat = o_wr_pull && (beats_sent + 1'b1 >= beats_lim);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_run     <= 1'b0;
      wr_delay   <= '0;
      beats_sent <= '0;
      beats_lim  <= '0;
      o_wr_pull  <= 1'b0;
    end else begin
      if (wr_delay != '0) wr_delay <= wr_delay - 1'b1;
      o_wr_pull <= wr_run && ((wr_delay == W'(1)) || (o_wr_pull && !last_beat)); // R23
      if (o_wr_pull) beats_sent <= beats_sent + 1'b1;
      if (last_beat) wr_run <= 1'b0;
      if (do_access && is_wr) begin
        wr_run     <= 1'b1;
        wr_delay   <= WR_LEAD;
        beats_sent <= '0;
        beats_lim  <= FULL_BEATS;
      end else if (do_stop && last_wr) begin
        beats_lim <= eff_beats; // R3
      end
    end
  end

  // Mask travels in the same flop stage as its data beat
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dq              <= '0;
      o_write_byte_mask <= '0;
      o_dq_oe           <= 1'b0;
      o_dqs             <= 1'b0;
      o_dqs_oe          <= 1'b0;
    end else begin
      o_dq_oe  <= o_wr_pull;
      o_dqs_oe <= o_wr_pull;
      o_dqs    <= o_wr_pull ? ~o_dqs : 1'b0;
      o_write_byte_mask <= o_wr_pull ? i_wr_mask : '0; // R9
      if (o_wr_pull) o_dq <= i_wr_data;
    end
  end

endmodule : sbc_ctrl
`default_nettype wire

/* sbc_pkg.sv */
// Shared constants and types for the memory command controller
package sbc_pkg;

  // ****************************************
  // Clocking
  // ****************************************
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int MEM_CLK_DIV     = 2;
  localparam int MEM_PERIOD_NS   = CLOCK_PERIOD_NS * MEM_CLK_DIV;

  // ****************************************
  // Device defaults and analog times in ns
  // ****************************************
  localparam int NUM_BANKS_DEF            = 8;
  localparam int BURST_LENGTH_DEF         = 8;
  localparam int READ_LATENCY_DEF         = 6;
  localparam int WRITE_LATENCY_DEF        = 3;
  localparam int DATA_BYTES_DEF           = 4;
  localparam int ALL_BANK_CLOSE_TIME_NS   = 21;
  localparam int SINGLE_BANK_CLOSE_TIME_NS = 18;
  localparam int READ_TO_CLOSE_TIME_NS    = 8;
  localparam int WRITE_RECOVERY_TIME_NS   = 15;
  localparam int ROW_ACTIVE_MIN_TIME_NS   = 42;
  localparam int ROW_CYCLE_TIME_NS        = 60;
  localparam int OUTPUT_STROBE_SKEW_NS    = 6;
  localparam int WRITE_TO_READ_TIME_NS    = 8;

  // ****************************************
  // Least times rounded up to memory clock cycles
  // ****************************************
  localparam int ALL_BANK_CLOSE_CYC   = (ALL_BANK_CLOSE_TIME_NS + MEM_PERIOD_NS - 1) / MEM_PERIOD_NS;
  localparam int SINGLE_CLOSE_CYC     = (SINGLE_BANK_CLOSE_TIME_NS + MEM_PERIOD_NS - 1)
                                        / MEM_PERIOD_NS;
  localparam int READ_TO_CLOSE_CYC    = (READ_TO_CLOSE_TIME_NS + MEM_PERIOD_NS - 1) / MEM_PERIOD_NS;
  localparam int WRITE_RECOVERY_CYC   = (WRITE_RECOVERY_TIME_NS + MEM_PERIOD_NS - 1) / MEM_PERIOD_NS;
  localparam int ROW_ACTIVE_MIN_CYC   = (ROW_ACTIVE_MIN_TIME_NS + MEM_PERIOD_NS - 1) / MEM_PERIOD_NS;
  localparam int ROW_CYCLE_CYC        = (ROW_CYCLE_TIME_NS + MEM_PERIOD_NS - 1) / MEM_PERIOD_NS;
  localparam int OUTPUT_STROBE_SKEW_CYC = (OUTPUT_STROBE_SKEW_NS + MEM_PERIOD_NS - 1)
                                          / MEM_PERIOD_NS;
  localparam int WRITE_TO_READ_CYC    = (WRITE_TO_READ_TIME_NS + MEM_PERIOD_NS - 1) / MEM_PERIOD_NS;

  // ****************************************
  // Command-address layout
  // ****************************************
  localparam int CA_WIDTH        = 10;
  localparam int ALL_BANK_BIT    = 4;
  localparam int BANK_LSB        = 7;
  localparam int AUTO_CLOSE_BIT  = 0;
  localparam logic [3:0] CA_BURST_STOP = 4'h3;
  localparam logic [3:0] CA_BANK_CLOSE = 4'hb;
  localparam logic [2:0] CA_READ       = 3'h5;
  localparam logic [2:0] CA_WRITE      = 3'h1;
  localparam logic [1:0] CA_ACTIVATE   = 2'h2;
  localparam int CNT_W           = 8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    REQ_ACTIVATE = 3'h0,
    REQ_READ     = 3'h1,
    REQ_WRITE    = 3'h2,
    REQ_CLOSE    = 3'h3,
    REQ_STOP     = 3'h4
  } sbc_req_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RISE = 2'h1,
    ST_FALL = 2'h3
  } sbc_state_type;

endpackage : sbc_pkg

/* sbc_bank_if.sv */
// Strobes and status between the command sequencer and the bank trackers
`timescale 1ns/10ps
`default_nettype none
interface sbc_bank_if #(
  parameter int NB = 8
);
  logic                      tick;
  logic [NB-1:0]             act;
  logic [NB-1:0]             close;
  logic [NB-1:0]             acc;
  logic                      acc_auto;
  logic [sbc_pkg::CNT_W-1:0] acc_close_wait;
  logic [sbc_pkg::CNT_W-1:0] auto_wait;
  logic [sbc_pkg::CNT_W-1:0] close_time;
  wire  [NB-1:0]             is_open;
  wire  [NB-1:0]             may_close;
  wire  [NB-1:0]             may_act;
  wire  [NB-1:0]             may_acc;

  modport ctrl (
    output tick, act, close, acc, acc_auto, acc_close_wait, auto_wait, close_time,
    input  is_open, may_close, may_act, may_acc
  );
  modport bank (
    input  tick, act, close, acc, acc_auto, acc_close_wait, auto_wait, close_time,
    output is_open, may_close, may_act, may_acc
  );
endinterface : sbc_bank_if
`default_nettype wire

/* sbc_bank.sv */
// Per-bank open state and spacing timers
`timescale 1ns/10ps
`default_nettype none
module sbc_bank #(
  parameter int IDX       = 0,
  parameter int RAS_CYC   = sbc_pkg::ROW_ACTIVE_MIN_CYC,
  parameter int RC_CYC    = sbc_pkg::ROW_CYCLE_CYC,
  parameter int CLOSE_CYC = sbc_pkg::SINGLE_CLOSE_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Sequencer side
  sbc_bank_if.bank bus
);
  localparam int W = sbc_pkg::CNT_W;

  logic         open;
  logic [W-1:0] close_wait;
  logic [W-1:0] ras_wait;
  logic [W-1:0] rc_wait;
  logic [W-1:0] prep_wait;
  logic [W-1:0] auto_wait;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      open       <= 1'b0;
      close_wait <= '0;
      ras_wait   <= '0;
      rc_wait    <= '0;
      prep_wait  <= '0;
      auto_wait  <= '0;
    end else begin
      if (bus.tick) begin
        if (close_wait != '0) close_wait <= close_wait - 1'b1;
        if (ras_wait != '0) ras_wait <= ras_wait - 1'b1;
        if (rc_wait != '0) rc_wait <= rc_wait - 1'b1;
        if (prep_wait != '0) prep_wait <= prep_wait - 1'b1;
        if (auto_wait != '0) auto_wait <= auto_wait - 1'b1;
      end
      // Automatic close starts its own close interval
      if (bus.tick && auto_wait == W'(1)) begin // R21 R24
        open      <= 1'b0;
        prep_wait <= W'(CLOSE_CYC); // R22
      end
      if (bus.act[IDX]) begin
        open     <= 1'b1;
        ras_wait <= W'(RAS_CYC); // R14
        rc_wait  <= W'(RC_CYC); // R22
      end
      if (bus.close[IDX]) begin
        open      <= 1'b0;
        prep_wait <= bus.close_time; // R12 R16
      end
      if (bus.acc[IDX]) begin
        close_wait <= bus.acc_close_wait; // R15 R17 R18
        if (bus.acc_auto) auto_wait <= bus.auto_wait; // R20
      end
    end
  end

  assign bus.is_open[IDX]   = open; // R25
  // A count of one is its last tick, so the command may already go
  assign bus.may_close[IDX] = (close_wait <= W'(1)) && (ras_wait <= W'(1)) && (auto_wait == '0);
  assign bus.may_act[IDX]   = !open && (prep_wait <= W'(1)) && (rc_wait <= W'(1))
                              && (auto_wait == '0); // R16 R22
  assign bus.may_acc[IDX]   = open && (auto_wait == '0);

endmodule : sbc_bank
`default_nettype wire

/* sbc_mem_model.sv */
// Behavioural memory device watching the command pins
`timescale 1ns/10ps
`default_nettype none
module sbc_mem_model (
  // Pins
  input  wire logic       i_mem_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_cs_n,
  input  wire logic [9:0] i_ca,
  // Status
  output logic      [7:0] o_open
);
  // ****
  // Decode
  // ****
  // Pins seen through a hold delay, so the edge samples the old word
  wire       #2 cs_d = i_cs_n;
  wire [9:0] #2 ca_d = i_ca;
  logic [3:0]   rise;
  logic [2:0]   bank;
  logic         ap;
  always @(posedge i_mem_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_open <= 8'h0;
      rise   <= 4'h0;
    end else begin
      if (ap) o_open[bank] <= 1'b0;
      rise <= cs_d ? 4'h0 : ca_d[3:0];
      bank <= ca_d[9:7];
      if (!cs_d && ca_d[1:0] == 2'h2) o_open[ca_d[9:7]] <= 1'b1;
      if (!cs_d && ca_d[3:0] == 4'hb) begin
        if (ca_d[4]) o_open <= 8'h0;
        else o_open[ca_d[9:7]] <= 1'b0;
      end
    end
  end
  // Auto-close applied one clock after its command; the bench waits the real delay
  always @(negedge i_mem_clk) ap <= i_nrst && rise[1:0] == 2'h1 && ca_d[0];
endmodule : sbc_mem_model
`default_nettype wire

/* sbc_ctrl_props.sv */
// Port assertions for the memory command controller
`timescale 1ns/10ps
`default_nettype none
module sbc_ctrl_props #(
  parameter int DATA_BYTES = 4
) (
  // Observed ports
  input wire logic                  i_clock, i_nrst, i_req_valid, o_req_done, o_req_err,
  input wire logic                  o_wr_pull, o_mem_clk, o_cs_n, o_dq_oe, o_dqs, o_dqs_oe,
  input wire logic [9:0]            o_ca,
  input wire logic [DATA_BYTES-1:0] o_write_byte_mask
);
  // ****
  // Properties
  // ****
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_rise; !o_cs_n && !o_mem_clk; endsequence
  sequence s_fall; !o_cs_n && o_mem_clk; endsequence
  property p_excl; !(o_req_done && o_req_err); endproperty
  a_excl: assert property (p_excl) else $error("done and refusal together");
  property p_cause; (o_req_done || o_req_err) |-> $past(i_req_valid); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_issue; o_req_done |-> s_rise ##1 s_fall; endproperty
  a_issue: assert property (p_issue) else $error("command word pair missing");
  property p_code; (!o_cs_n && !o_mem_clk && o_ca[1:0] == 2'h3) |-> !o_ca[2]; endproperty
  a_code: assert property (p_code) else $error("bad stop or close code");
  property p_idle; o_cs_n |-> o_ca == 10'h0; endproperty
  a_idle: assert property (p_idle) else $error("bus not quiet");
  property p_wstart; (!o_cs_n && !o_mem_clk && o_ca[2:0] == 3'h1) |-> ##7 o_wr_pull; endproperty
  a_wstart: assert property (p_wstart) else $error("write beats late");
  property p_wlen; $rose(o_wr_pull) |-> o_wr_pull[*4]; endproperty
  a_wlen: assert property (p_wlen) else $error("burst shorter than four");
  property p_dq; o_wr_pull |=> o_dq_oe && o_dqs_oe; endproperty
  a_dq: assert property (p_dq) else $error("data not driven");
  property p_dqs; (o_dqs_oe && $past(o_dqs_oe)) |-> o_dqs != $past(o_dqs); endproperty
  a_dqs: assert property (p_dqs) else $error("strobe stuck");
  property p_mask; (o_write_byte_mask != '0) |-> o_dq_oe; endproperty
  a_mask: assert property (p_mask) else $error("mask outside data");
endmodule : sbc_ctrl_props
bind sbc_ctrl sbc_ctrl_props #(.DATA_BYTES(DATA_BYTES)) u_props (.i_clock, .i_nrst,
  .i_req_valid, .o_req_done, .o_req_err, .o_wr_pull, .o_mem_clk, .o_cs_n, .o_dq_oe, .o_dqs,
  .o_dqs_oe, .o_ca, .o_write_byte_mask);
`default_nettype wire

/* tb.sv */
// Self-checking bench for the memory command controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                 i_clock = 1'b0;
  logic                 i_nrst = 1'b1;
  logic                 i_req_valid = 1'b0, i_req_auto_close = 1'b0, i_req_all_banks = 1'b0;
  logic [2:0]           i_req_bank = 3'h0;
  sbc_pkg::sbc_req_type i_req_cmd = sbc_pkg::REQ_ACTIVATE;
  logic [31:0]          i_wr_data = 32'h0;
  logic [3:0]           i_wr_mask = 4'h0;
  logic                 o_req_done, o_req_err, o_wr_pull, o_mem_clk, o_cs_n;
  logic                 o_dq_oe, o_dqs, o_dqs_oe;
  logic [9:0]           o_ca;
  logic [31:0]          o_dq;
  logic [3:0]           o_write_byte_mask;
  logic [7:0]           open_banks;
  int                   errors = 0, compares = 0, cyc = 0, seed = 80, pulls = 0;
  sbc_ctrl uut (.i_clock, .i_nrst, .i_req_valid, .i_req_cmd, .i_req_bank, .i_req_auto_close,
    .i_req_all_banks, .o_req_done, .o_req_err, .o_wr_pull, .i_wr_data, .i_wr_mask, .o_mem_clk,
    .o_cs_n, .o_ca, .o_dq, .o_dq_oe, .o_write_byte_mask, .o_dqs, .o_dqs_oe);
  sbc_mem_model mem (.i_mem_clk(o_mem_clk), .i_nrst, .i_cs_n(o_cs_n), .i_ca(o_ca),
    .o_open(open_banks));
  // ****
  // Tasks
  // ****
  task automatic stop_test();
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Valid stays high across back-to-back requests, one per memory cycle
  task automatic req(input sbc_pkg::sbc_req_type c, input logic [2:0] b, input logic ac,
                     input logic ab, output logic [1:0] r);
    {i_req_cmd, i_req_bank, i_req_auto_close, i_req_all_banks, i_req_valid} = {c, b, ac, ab, 1'b1};
    r = 2'h0;
    for (int k = 0; k < 8 && r == 2'h0; k++) begin
      @(negedge i_clock);
      r = {o_req_done, o_req_err};
    end
  endtask : req
  // Retries every memory cycle; the refusal count shows the spacing enforced
  task automatic until_ok(input sbc_pkg::sbc_req_type c, input logic [2:0] b, input logic ab,
                          input int exp_n);
    logic [1:0] r;
    int         n;
    n = 0;
    req(c, b, 1'b0, ab, r);
    while (r == 2'h1 && n < 20) begin
      n++;
      req(c, b, 1'b0, ab, r);
    end
    chk(n, exp_n);
  endtask : until_ok
  always #4 i_clock = ~i_clock;
  always @(negedge i_clock) begin
    i_wr_data <= $random(seed);
    i_wr_mask <= 4'($random(seed));
    cyc++;
    pulls += o_wr_pull;
    if (cyc > 2000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    logic [1:0] r;
    logic [2:0] b;
    b = 3'($random(seed));
    #1 i_nrst = 1'b0;
    repeat (8) @(negedge i_clock);
    i_nrst = 1'b1;
    @(negedge i_clock);
    req(sbc_pkg::REQ_ACTIVATE, b, 1'b0, 1'b0, r);
    chk(r, 2'h2);
    req(sbc_pkg::REQ_ACTIVATE, b, 1'b0, 1'b0, r);
    chk(r, 2'h1);
    req(sbc_pkg::REQ_WRITE, b, 1'b0, 1'b0, r);
    chk(r, 2'h2);
    req(sbc_pkg::REQ_STOP, b, 1'b0, 1'b0, r);
    chk(r, 2'h1);
    req(sbc_pkg::REQ_STOP, b, 1'b0, 1'b0, r);
    chk(r, 2'h2);
    req(sbc_pkg::REQ_STOP, b, 1'b0, 1'b0, r);
    chk(r, 2'h1);
    until_ok(sbc_pkg::REQ_CLOSE, b, 1'b0, sbc_pkg::WRITE_LATENCY_DEF + sbc_pkg::WRITE_RECOVERY_CYC - 1);
    until_ok(sbc_pkg::REQ_ACTIVATE, b, 1'b0, sbc_pkg::SINGLE_CLOSE_CYC - 1);
    req(sbc_pkg::REQ_READ, b, 1'b1, 1'b0, r);
    chk(r, 2'h2);
    until_ok(sbc_pkg::REQ_ACTIVATE, b, 1'b0, sbc_pkg::BURST_LENGTH_DEF / 2 + sbc_pkg::SINGLE_CLOSE_CYC
             + (sbc_pkg::READ_TO_CLOSE_CYC > 2 ? sbc_pkg::READ_TO_CLOSE_CYC : 2) - 3);
    req(sbc_pkg::REQ_ACTIVATE, b ^ 3'h4, 1'b0, 1'b0, r);
    chk(open_banks, 8'h1 << b);
    until_ok(sbc_pkg::REQ_CLOSE, b, 1'b1, sbc_pkg::ROW_ACTIVE_MIN_CYC - 1);
    i_req_valid = 1'b0;
    repeat (4) @(negedge i_clock);
    chk(open_banks, 8'h0);
    chk(pulls, 4);
    stop_test();
  end
endmodule : tb
`default_nettype wire
